// >>> cfrc_pkg.sv
package cfrc_pkg;
  // Command codes of the two fault response bytes
  localparam logic [7:0] OC_ACTION_CODE = 8'he5;
  localparam logic [7:0] UC_ACTION_CODE = 8'he6;
  // Field positions inside a response byte
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int COUNT_HI = 5;
  localparam int COUNT_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  // Field codes
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [2:0] COUNT_NO_RETRY = 3'h0;
  localparam logic [2:0] COUNT_FOREVER = 3'h7;
  // Reset value of both response bytes: disable and retry, no retry, 35 ms
  localparam logic [7:0] ACTION_RESET = 8'h80;
  // Channel indices
  localparam int CH_OC = 0;
  localparam int CH_UC = 1;
  localparam int NUM_CH = 2;
  // Timing: one retry step, in ms, at a 10 MHz clock
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RETRY_STEP_MS = 35;
  localparam int unsigned RETRY_STEP_CYCLES = RETRY_STEP_MS * (CLK_HZ / 1000);
  localparam int TIMER_W = 22;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] count;
    logic [2:0] delay;
  } cfrc_cfg_t;
endpackage : cfrc_pkg

// >>> cfrc_channel.sv
`timescale 1ns/1ps
module cfrc_channel #(
  parameter int unsigned STEP_CYCLES = cfrc_pkg::RETRY_STEP_CYCLES
) (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Configuration and conditions
  input cfrc_pkg::cfrc_cfg_t cfg,
  input wire logic fault,
  input wire logic stop_retry,
  input wire logic clear_fault,
  // Results
  output logic trip,
  output logic out_allow
);
  import cfrc_pkg::*;

  typedef enum logic [1:0] {RUN, DELAY, HOLD} cfrc_state_t;

  cfrc_state_t state;
  logic fault_d;
  logic fresh;
  logic [2:0] used;
  logic [2:0] step;
  logic [TIMER_W-1:0] tmr;
  logic shut_now;
  logic exhausted;
  logic delay_done;

  assign shut_now = (state == RUN) && fault && (cfg.mode == MODE_DISABLE_RETRY);
  // Rising edge reports every mode; a persisting fault after restart reports again
  assign trip = (fault && !fault_d) || shut_now;
  assign exhausted = (cfg.count == COUNT_NO_RETRY) ||
                     ((cfg.count != COUNT_FOREVER) && (used >= cfg.count));
  assign delay_done = (step == cfg.delay) && (tmr == TIMER_W'(STEP_CYCLES - 1));
  assign out_allow = (state == RUN);

  always_ff @(posedge clk) begin
    if (srst) begin
      fault_d <= 1'b0;
    end else if (ce) begin
      fault_d <= fault;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= RUN;
      tmr <= '0;
      step <= '0;
    end else if (ce) begin
      unique case (state)
        RUN: begin
          tmr <= '0;
          step <= '0;
          if (shut_now) begin
            state <= exhausted ? HOLD : DELAY; // R02 R04
          end
        end
        DELAY: begin
          if (stop_retry) begin
            state <= HOLD; // R05
          end else if (delay_done) begin
            state <= RUN; // R06
          end else if (tmr == TIMER_W'(STEP_CYCLES - 1)) begin
            tmr <= '0;
            step <= step + 3'h1; // R06
          end else begin
            tmr <= tmr + TIMER_W'(1);
          end
        end
        HOLD: begin
          if (clear_fault) begin
            state <= RUN; // R04
          end
        end
        // The spare code parks the output off until the host clears
        default: begin
          state <= HOLD;
        end
      endcase
    end
  end

  // Attempt counter; a clean first cycle after a restart earns a fresh budget
  always_ff @(posedge clk) begin
    if (srst) begin
      used <= '0;
      fresh <= 1'b0;
    end else if (ce) begin
      fresh <= (state == DELAY) && delay_done && !stop_retry;
      if (clear_fault || (fresh && !fault && state == RUN)) begin
        used <= '0; // R10
      end else if (state == DELAY && delay_done && !stop_retry && cfg.count != COUNT_FOREVER) begin
        used <= used + 3'h1; // R03
      end
    end
  end

  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (srst);

  // Helper: cycles spent in the delay state
  logic [TIMER_W+1:0] dly_cycles;
  always_ff @(posedge clk) begin
    if (srst || state != DELAY) begin
      dly_cycles <= '0;
    end else if (ce) begin
      dly_cycles <= dly_cycles + (TIMER_W+2)'(1);
    end
  end

  no_retry_hold_a: assert property (shut_now && cfg.count == COUNT_NO_RETRY |=> state == HOLD) // R04
    else $error("zero retry count did not hold the output off");
  retry_delay_len_a: assert property (state == DELAY && delay_done && !stop_retry |->
      dly_cycles == (TIMER_W+2)'((cfg.delay + 1) * STEP_CYCLES - 1)) // R06
    else $error("retry delay length wrong");
  forever_retry_a: assert property (state == DELAY && cfg.count == COUNT_FOREVER && !stop_retry
      |=> state != HOLD) // R05
    else $error("continuous retry gave up");
  attempt_limit_a: assert property (cfg.count != COUNT_FOREVER && cfg.count != COUNT_NO_RETRY &&
      $stable(cfg) |-> used <= cfg.count) // R03
    else $error("more restarts than programmed");
  reload_clear_a: assert property (clear_fault |=> used == 3'h0) // R10
    else $error("attempt counter not reloaded on clear");
endmodule : cfrc_channel

// >>> cfrc_top.sv
`timescale 1ns/1ps
// How it works
// R01 - Every response mode pulls the alert line low and sets the fault status bit.
// R02 - Mode 10 switches the output off at once, then restarts per the count.
// R03 - Counts one to six give exactly that many restart attempts.
// R04 - Count 000 never restarts; output stays off until the fault is cleared.
// R05 - Count 111 retries forever until commanded off, bias lost or other shutdown.
// R06 - Delay between attempts is (retry time + 1) times 35 ms.
// R07 - The overcurrent byte uses the standard format and sets the overcurrent bit.
// R08 - The undercurrent byte uses the standard format and sets the undercurrent bit.
// R09 - Both bytes are read and written as single bytes; reads return last write.
// R10 - Attempt budget reloads on fault clear or on a clean restart.
module cfrc_top #(
  parameter int unsigned STEP_CYCLES = cfrc_pkg::RETRY_STEP_CYCLES
) (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // Byte command port from the bus transport
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_rvalid,
  input wire logic clear_faults,
  // Fault comparators and power pins
  input wire logic oc_fault_pin,
  input wire logic uc_fault_pin,
  input wire logic output_on_pin,
  input wire logic bias_ok_pin,
  // Alert line, open drain
  output logic alert_line_n_o,
  output logic alert_line_n_oe,
  // Status and power stage
  output logic status_oc,
  output logic status_uc,
  output logic output_enable
);
  import cfrc_pkg::*;

  localparam int NPIN = 4;

  logic [7:0] oc_action;
  logic [7:0] uc_action;
  cfrc_cfg_t cfg [NUM_CH];
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] sync_a;
  logic [NPIN-1:0] sync_b;
  logic [NUM_CH-1:0] fault_s;
  logic cmd_on;
  logic bias_ok;
  logic [NUM_CH-1:0] trip;
  logic [NUM_CH-1:0] allow;
  logic [NUM_CH-1:0] status;
  logic [NUM_CH-1:0] stop_retry;
  // Trips that must cut the output; report-only modes never do
  logic [NUM_CH-1:0] shut_req;

  assign pins_raw = {bias_ok_pin, output_on_pin, uc_fault_pin, oc_fault_pin};
  assign fault_s = sync_b[1:0];
  assign cmd_on = sync_b[2];
  assign bias_ok = sync_b[3];

  // Pins come from the analog side, so each passes two flops first
  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sync_a[gp] <= 1'b0;
          sync_b[gp] <= 1'b0;
        end else if (ce) begin
          sync_a[gp] <= pins_raw[gp];
          sync_b[gp] <= sync_a[gp];
        end
      end
    end
  endgenerate

  // Response bytes, single-byte writes
  always_ff @(posedge clk) begin
    if (srst) begin
      oc_action <= ACTION_RESET;
      uc_action <= ACTION_RESET;
    end else if (ce && cmd_wr) begin
      if (cmd_code == OC_ACTION_CODE) begin
        oc_action <= cmd_wdata; // R07 R09
      end
      if (cmd_code == UC_ACTION_CODE) begin
        uc_action <= cmd_wdata; // R08 R09
      end
    end
  end

  // Reads answer one cycle later; unknown codes return zero
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_rdata <= 8'h00;
      cmd_rvalid <= 1'b0;
    end else if (ce) begin
      cmd_rvalid <= cmd_rd;
      if (cmd_rd) begin
        unique case (cmd_code)
          OC_ACTION_CODE: cmd_rdata <= oc_action; // R09
          UC_ACTION_CODE: cmd_rdata <= uc_action; // R09
          default: cmd_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign cfg[CH_OC] = cfrc_cfg_t'(oc_action);
  assign cfg[CH_UC] = cfrc_cfg_t'(uc_action);

  // Retrying ends when the output is commanded off, bias drops, or the other channel shut down
  assign stop_retry[CH_OC] = !cmd_on || !bias_ok || !allow[CH_UC]; // R05
  assign stop_retry[CH_UC] = !cmd_on || !bias_ok || !allow[CH_OC]; // R05

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
      cfrc_channel #(
        .STEP_CYCLES(STEP_CYCLES)
      ) u_ch (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .cfg(cfg[gc]),
        .fault(fault_s[gc]),
        .stop_retry(stop_retry[gc]),
        .clear_fault(clear_faults),
        .trip(trip[gc]),
        .out_allow(allow[gc])
      );

      assign shut_req[gc] = trip[gc] && (cfg[gc].mode == MODE_DISABLE_RETRY); // R02

      // Sticky status: a trip in the clearing cycle wins
      always_ff @(posedge clk) begin
        if (srst) begin
          status[gc] <= 1'b0;
        end else if (ce) begin
          if (trip[gc]) begin
            status[gc] <= 1'b1; // R01 R07 R08
          end else if (clear_faults) begin
            status[gc] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign status_oc = status[CH_OC];
  assign status_uc = status[CH_UC];
  assign alert_line_n_o = 1'b0;
  assign alert_line_n_oe = |status; // R01

  // Output path is cut in the very cycle a channel decides to shut
  always_ff @(posedge clk) begin
    if (srst) begin
      output_enable <= 1'b0;
    end else if (ce) begin
      output_enable <= cmd_on && bias_ok && (&allow) && !(|shut_req); // R02
    end
  end

  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (srst);

  sequence wr_byte_s(logic [7:0] code);
    cmd_wr && cmd_code == code && !cmd_rd;
  endsequence

  sequence rd_back_s(logic [7:0] code);
    !cmd_wr && cmd_rd && cmd_code == code;
  endsequence

  alert_on_trip_a: assert property (|trip |=> !alert_line_n_o && alert_line_n_oe) // R01
    else $error("alert not asserted after a fault");
  oc_status_set_a: assert property (trip[CH_OC] |=> status_oc) // R07
    else $error("overcurrent status bit not set");
  uc_status_set_a: assert property (trip[CH_UC] |=> status_uc) // R08
    else $error("undercurrent status bit not set");
  status_sticky_a: assert property (status_oc && !clear_faults |=> status_oc) // R01
    else $error("overcurrent status dropped without a clear");
  output_cut_a: assert property (cfg[CH_OC].mode == MODE_DISABLE_RETRY && fault_s[CH_OC] && allow[CH_OC]
      |=> !output_enable ##1 !allow[CH_OC]) // R02
    else $error("output not switched off at once");
  oc_readback_a: assert property (
      wr_byte_s(OC_ACTION_CODE) ##1 rd_back_s(OC_ACTION_CODE) |=> cmd_rvalid && cmd_rdata == $past(cmd_wdata, 2)) // R09
    else $error("overcurrent byte read-back wrong");
  uc_readback_a: assert property (
      wr_byte_s(UC_ACTION_CODE) ##1 rd_back_s(UC_ACTION_CODE) |=> cmd_rvalid && cmd_rdata == $past(cmd_wdata, 2)) // R09
    else $error("undercurrent byte read-back wrong");
  bias_loss_off_a: assert property (!bias_ok |=> !output_enable) // R05
    else $error("output on without bias");
  cmd_off_stop_a: assert property (!cmd_on |=> !output_enable) // R05
    else $error("output on while commanded off");
  uc_output_cut_a: assert property (cfg[CH_UC].mode == MODE_DISABLE_RETRY && fault_s[CH_UC] && allow[CH_UC]
      |=> !output_enable ##1 !allow[CH_UC]) // R02
    else $error("output not switched off at once on undercurrent");
  report_only_a: assert property (trip[CH_OC] && cfg[CH_OC].mode != MODE_DISABLE_RETRY && !trip[CH_UC] &&
      cmd_on && bias_ok && (&allow) |=> output_enable) // R02
    else $error("report-only mode switched the output off");
  clear_status_a: assert property (clear_faults && !trip[CH_OC] |=> !status_oc) // R01
    else $error("overcurrent status not cleared");

  // Register port
  read_answer_a: assert property (cmd_rd |=> cmd_rvalid) // R09
    else $error("read not answered in one cycle");
  unmapped_zero_a: assert property (cmd_rd && cmd_code != OC_ACTION_CODE && cmd_code != UC_ACTION_CODE
      |=> cmd_rdata == 8'h00) // R09
    else $error("unmapped read returned nonzero data");
  rdata_hold_a: assert property (!cmd_rd |=> $stable(cmd_rdata)) // R09
    else $error("read data changed without a read");
endmodule : cfrc_top

// >>> cfrc_host.sv
`timescale 1ns/1ps
module cfrc_host (
  // Clock
  input wire logic clk,
  // Byte command port
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_wdata,
  input wire logic [7:0] cmd_rdata,
  input wire logic cmd_rvalid
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr = 1'b0;
    // Released lines must not look valid, so they are scrambled
    cmd_code = ~c;
    cmd_wdata = ~d;
    // An idle edge keeps a following call from re-raising a strobe in the same time step
    @(posedge clk);
    #1;
  endtask : wr

  // Write, then read the same byte in the very next cycle
  task automatic wr_rd(input logic [7:0] c, input logic [7:0] d, output logic [7:0] v, output logic ok);
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(posedge clk);
    #1;
    cmd_wr = 1'b0;
    cmd_rd = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
    ok = cmd_rvalid;
    v = cmd_rdata;
    @(posedge clk);
    #1;
  endtask : wr_rd

  task automatic rd(input logic [7:0] c, output logic [7:0] v, output logic ok);
    cmd_code = c;
    cmd_rd = 1'b1;
    @(posedge clk);
    #1;
    cmd_rd = 1'b0;
    cmd_code = ~c;
    ok = cmd_rvalid;
    v = cmd_rdata;
    @(posedge clk);
    #1;
  endtask : rd
endmodule : cfrc_host

// >>> cfrc_tb_top.sv
`timescale 1ns/1ps
module cfrc_tb_top;
  import cfrc_pkg::*;
  // Short retry step keeps the run small
  localparam int unsigned S = 20;
  logic clk = 0, srst = 1, clear_faults = 0, oc = 0, uc = 0, on_pin = 1, bias_pin = 1;
  logic [7:0] code, wdata, rdata, v, wd;
  logic wr, rd, rvalid, ok, alert_o, alert_oe, st_oc, st_uc, out_en;
  int fail_count = 0, tests_run = 0, cyc = 0, t;
  always #50 clk = ~clk;
  cfrc_top #(.STEP_CYCLES(S)) dut (.clk(clk), .srst(srst), .ce(1'b1), .cmd_code(code), .cmd_wr(wr),
    .cmd_rd(rd), .cmd_wdata(wdata), .cmd_rdata(rdata), .cmd_rvalid(rvalid), .clear_faults(clear_faults),
    .oc_fault_pin(oc), .uc_fault_pin(uc), .output_on_pin(on_pin), .bias_ok_pin(bias_pin),
    .alert_line_n_o(alert_o), .alert_line_n_oe(alert_oe), .status_oc(st_oc), .status_uc(st_uc),
    .output_enable(out_en));
  cfrc_host host (.clk(clk), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd), .cmd_wdata(wdata),
    .cmd_rdata(rdata), .cmd_rvalid(rvalid));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      final_report();
    end
  end

  function automatic int period(input logic [2:0] d);
    return (int'(d) + 1) * S;
  endfunction : period

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic pin(input bit ch, input logic lv);
    if (ch) uc = lv;
    else oc = lv;
  endtask : pin

  task automatic wait_on(input int lim);
    t = 0;
    while (out_en !== 1'b1 && t < lim) begin
      step(1);
      t++;
    end
  endtask : wait_on

  task automatic trip(input bit ch, input logic [1:0] mode);
    pin(ch, 1'b1);
    step(3);
    check("status", ch ? st_uc : st_oc, 1);
    check("alert", {alert_o, alert_oe}, 2'b01);
    check("output off", out_en, mode != MODE_DISABLE_RETRY);
  endtask : trip

  task automatic clear();
    clear_faults = 1'b1;
    step(1);
    clear_faults = 1'b0;
    step(1);
    check("status clear", {st_oc, st_uc, alert_oe}, 3'b000);
    wait_on(10);
    check("released", out_en, 1);
  endtask : clear

  // Fault held through k restart waits, then removed
  task automatic retry(input bit ch, input logic [2:0] n, input logic [2:0] d, input int k);
    host.wr(ch ? UC_ACTION_CODE : OC_ACTION_CODE, {MODE_DISABLE_RETRY, n, d});
    trip(ch, MODE_DISABLE_RETRY);
    step(k * period(d) + period(d) / 2);
    pin(ch, 1'b0);
    wait_on(2 * period(d) + 10);
    check("restart", out_en, k < int'(n) || n == COUNT_FOREVER);
    clear();
  endtask : retry

  initial begin
    wd = 8'($urandom(32'h3e2e4c70));
    step(12);
    srst = 1'b0;
    for (int i = 0; i < 2; i++) begin
      host.rd(i ? UC_ACTION_CODE : OC_ACTION_CODE, v, ok);
      check("reset byte", {ok, v}, {1'b1, ACTION_RESET});
    end
    host.rd(8'he7, v, ok);
    check("unmapped", {ok, v}, 9'h100);
    repeat (4) begin
      for (int i = 0; i < 2; i++) begin
        wd = 8'($urandom);
        host.wr(i ? UC_ACTION_CODE : OC_ACTION_CODE, wd);
        host.wr(8'he4, ~wd);
        host.rd(i ? UC_ACTION_CODE : OC_ACTION_CODE, v, ok);
        check("readback", v, wd);
        host.wr_rd(i ? UC_ACTION_CODE : OC_ACTION_CODE, ~wd, v, ok);
        check("write then read", {ok, v}, {1'b1, ~wd});
      end
    end
    for (int i = 0; i < 3; i++) begin
      wd = {2'(i == 2 ? 3 : i), 6'($urandom)};
      host.wr(wd[6] ? UC_ACTION_CODE : OC_ACTION_CODE, wd);
      trip(wd[6], wd[7:6]);
      pin(wd[6], 1'b0);
      clear();
    end
    for (int i = 0; i < 2; i++) begin
      wd = 8'($urandom_range(7, 0));
      host.wr(i ? UC_ACTION_CODE : OC_ACTION_CODE, {MODE_DISABLE_RETRY, 3'h1, wd[2:0]});
      trip(i[0], MODE_DISABLE_RETRY);
      pin(i[0], 1'b0);
      wait_on(2 * period(wd[2:0]));
      check("retry delay", t + 2 >= period(wd[2:0]) && t <= period(wd[2:0]) + 2, 1);
      // A clean restart must earn a fresh budget without a clear
      trip(i[0], MODE_DISABLE_RETRY);
      pin(i[0], 1'b0);
      wait_on(2 * period(wd[2:0]));
      check("budget reload", out_en, 1);
      clear();
    end
    for (int n = 0; n < 8; n++) begin
      wd = 8'($urandom_range(7, 2));
      if (n > 0 && n < 7) retry(n[0], 3'(n), wd[2:0], n - 1);
      retry(n[0], 3'(n), wd[2:0], n == 7 ? 8 : n);
    end
    // Continuous retry stops when the output is commanded off or bias drops
    for (int j = 0; j < 2; j++) begin
      host.wr(j ? UC_ACTION_CODE : OC_ACTION_CODE, {MODE_DISABLE_RETRY, COUNT_FOREVER, 3'h0});
      trip(j[0], MODE_DISABLE_RETRY);
      step(5);
      if (j) bias_pin = 1'b0;
      else on_pin = 1'b0;
      step(5);
      on_pin = 1'b1;
      bias_pin = 1'b1;
      pin(j[0], 1'b0);
      wait_on(2 * period(3'h0) + 10);
      check("stopped retry", out_en, 0);
      clear();
    end
    final_report();
  end
endmodule : cfrc_tb_top
